// [verilog/xirq_pkg.sv]
`default_nettype none
package xirq_pkg;
  // Avalon word byte addresses
  localparam logic [5:0] ROUTE0_OFS = 6'h00;
  localparam logic [5:0] ROUTE1_OFS = 6'h04;
  localparam logic [5:0] ROUTE2_OFS = 6'h08;
  localparam logic [5:0] ROUTE3_OFS = 6'h0C;
  localparam logic [5:0] TRAP_FLAG_OFS = 6'h10;
  localparam logic [5:0] EVT_STATUS_OFS = 6'h14;
  localparam logic [5:0] EVT_MASK_OFS = 6'h18;
  localparam logic [5:0] TRAP_STATE_OFS = 6'h1C;
  localparam logic [15:0] ROUTE_RESET = 16'h0000;
  localparam logic [15:0] TRAP_FLAG_RESET = 16'h0000;
  localparam logic [3:0] EVT_MASK_RESET = 4'h0;
  localparam int ROUTE_EN_LSB = 8;
  localparam int NUM_VEC = 4;
  localparam int NUM_SRC = 14;
  // Source indices
  localparam int SRC_CAN_A = 0;
  localparam int SRC_CAN_B = 1;
  localparam int SRC_I2C_RX = 2;
  localparam int SRC_I2C_TX = 3;
  localparam int SRC_I2C_ERR = 4;
  localparam int SRC_SSC_RX = 5;
  localparam int SRC_SSC_TX = 6;
  localparam int SRC_SSC_ERR = 7;
  localparam int SRC_ASC_RX = 8;
  localparam int SRC_ASC_TX = 9;
  localparam int SRC_ASC_TXB = 10;
  localparam int SRC_ASC_ERR = 11;
  localparam int SRC_PLL_OSC = 12;
  localparam int SRC_PWM = 13;
  // Slot of the CAN source in vectors 0 and 1 (low byte of route regs)
  localparam logic [7:0] SLOT_CAN = 8'h00;
  // Routing: which source sits on which bit of each vector
  // Vectors 0..2: bit0 CAN(0->CAN_A,1->CAN_B,2->PWM), bits1..7 rx/tx sources
  // Vector 3: bits0..6 CAN_A, CAN_B, I2C err, SSC err, ASC err, PLL/OSC, PWM
  localparam logic [15:0] VEC_RESET_LOC = 16'h0000;
  localparam logic [15:0] VEC_NMI_LOC = 16'h0008;
  localparam logic [15:0] VEC_STACK_OVERFLOW_FLAG_LOC = 16'h0010;
  localparam logic [15:0] VEC_STACK_UNDERFLOW_FLAG_LOC = 16'h0018;
  localparam logic [15:0] VEC_CLASSB_LOC = 16'h0028;
  localparam logic [7:0] TRAPNO_RESET = 8'h00;
  localparam logic [7:0] TRAPNO_NMI = 8'h02;
  localparam logic [7:0] TRAPNO_STACK_OVERFLOW_FLAG = 8'h04;
  localparam logic [7:0] TRAPNO_STACK_UNDERFLOW_FLAG = 8'h06;
  localparam logic [7:0] TRAPNO_CLASSB = 8'h0A;
  localparam logic [3:0] ILVL_MAX = 4'hF;
  // Trap flag bit positions
  localparam int TF_NMI = 15;
  localparam int TF_STACK_OVERFLOW_FLAG = 14;
  localparam int TF_STACK_UNDERFLOW_FLAG = 13;
  localparam int TF_UNDEFINED_OPCODE_FLAG = 7;
  localparam int TF_PROTECTED_INSTR_FAULT_FLAG = 3;
  localparam int TF_ILLEGAL_OPERAND_FLAG = 2;
  localparam int TF_ILLEGAL_FETCH_FLAG = 1;
  localparam int TF_ILLEGAL_EXT_BUS_FLAG = 0;
  localparam int TF_MAC = 6;
  typedef enum logic [1:0] {
    PRIO_NONE = 2'b00,
    PRIO_CLASS_B = 2'b01,
    PRIO_CLASS_A = 2'b10,
    PRIO_RESET = 2'b11
  } trap_prio_t;
  typedef struct packed {
    logic valid;
    trap_prio_t prio;
    logic [7:0] number;
    logic [15:0] vector;
    logic [3:0] ilvl;
  } trap_entry_t;
  typedef struct packed {
    logic nmi;
    logic stack_over;
    logic stack_under;
    logic undef_opcode;
    logic mac_trap;
    logic prot_fault;
    logic ill_operand;
    logic ill_fetch;
    logic ill_ext_bus;
  } trap_req_t;
endpackage
`default_nettype wire

// [verilog/xperiph_irq_mux.sv]
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Four 16-bit routing registers, one per shared peripheral vector.
// - The high byte of each routing register holds the per-source enables.
// - The low byte of each routing register holds the per-source flags.
// - A shared vector requests only through enabled sources, any of which may drive it.
// - A flag sets on its event whether or not its enable is set.
// - Two-wire, serial and async receive/transmit plus async transmit-buffer go to vectors 0-2.
// - Error requests and the PLL-unlock/oscillator-watchdog request go only to vector 3.
// - CAN A goes to vectors 0 and 3, CAN B to 1 and 3, the PWM channel to 2 and 3.
// - All resets use trap number 00h, vector 00'0000h, at the highest priority.
// - NMI, stack overflow and underflow use vectors 08h, 10h, 18h and numbers 02h, 04h, 06h.
// - Class A traps rank below resets and above class B traps.
// - Class B traps share number 0Ah and vector 00'0028h at the lowest trap level.
// - Six class B sources each own a trap flag.
// - Servicing a reset or hardware trap forces the CPU interrupt level to 15.
// - Every hardware trap sets its own bit in the trap flag register.
// - While a trap service runs, standard interrupts and event transfers are held off.
module xperiph_irq_mux (
  input wire logic core_clk, // CPU clock
  input wire logic reset_n, // Synchronous reset, low active
  input wire logic [5:0] avs_address, // Byte address
  input wire logic avs_read, // Read strobe
  input wire logic avs_write, // Write strobe
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  input wire logic [xirq_pkg::NUM_SRC-1:0] src_event, // One-cycle source events
  input wire xirq_pkg::trap_req_t trap_event, // One-cycle hardware trap events
  input wire logic reset_event, // Software or watchdog reset request
  input wire logic trap_ack, // Core has taken the pending trap
  input wire logic trap_done, // Core leaves the trap service
  output logic [xirq_pkg::NUM_VEC-1:0] shared_vector_req, // Shared vector requests 0..3
  output xirq_pkg::trap_entry_t trap_out, // Pending trap entry
  output logic [3:0] cpu_interrupt_level, // Forced level while in service
  output logic level_force, // Load cpu_interrupt_level into status word
  output logic std_irq_block, // Hold off standard irqs and transfers
  output logic irq // Event interrupt, level
);
  logic [15:0] route_r [xirq_pkg::NUM_VEC];
  logic [15:0] route_nxt [xirq_pkg::NUM_VEC];
  logic [15:0] tflag_r, tflag_nxt;
  logic [3:0] evt_stat_r, evt_stat_nxt;
  logic [3:0] evt_mask_r, evt_mask_nxt;
  logic in_service_r, in_service_nxt;
  logic reset_pend_r, reset_pend_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [7:0] vec_event [xirq_pkg::NUM_VEC];
  logic [15:0] trap_set;
  logic wr, rd;
  xirq_pkg::trap_entry_t pend;

  // Maps source events to the eight flag slots of one vector
  function automatic logic [7:0] slot_events(input int v,
      input logic [xirq_pkg::NUM_SRC-1:0] e);
    logic [7:0] s;
    s = 8'h00;
    if (v < 3) begin
      // Slot 0 is the vector's private CAN or PWM source
      s[0] = (v == 0) ? e[xirq_pkg::SRC_CAN_A] :
             (v == 1) ? e[xirq_pkg::SRC_CAN_B] : e[xirq_pkg::SRC_PWM];
      s[1] = e[xirq_pkg::SRC_I2C_RX];
      s[2] = e[xirq_pkg::SRC_I2C_TX];
      s[3] = e[xirq_pkg::SRC_SSC_RX];
      s[4] = e[xirq_pkg::SRC_SSC_TX];
      s[5] = e[xirq_pkg::SRC_ASC_RX];
      s[6] = e[xirq_pkg::SRC_ASC_TX];
      s[7] = e[xirq_pkg::SRC_ASC_TXB];
    end else begin
      s[0] = e[xirq_pkg::SRC_CAN_A];
      s[1] = e[xirq_pkg::SRC_CAN_B];
      s[2] = e[xirq_pkg::SRC_I2C_ERR];
      s[3] = e[xirq_pkg::SRC_SSC_ERR];
      s[4] = e[xirq_pkg::SRC_ASC_ERR];
      s[5] = e[xirq_pkg::SRC_PLL_OSC];
      s[6] = e[xirq_pkg::SRC_PWM];
    end
    return s;
  endfunction

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
      input logic [15:0] d, input logic [1:0] be);
    merge16 = old;
    if (be[0]) merge16[7:0] = d[7:0];
    if (be[1]) merge16[15:8] = d[15:8];
  endfunction

  // Writes land on the completing edge, where waitrequest is low
  assign wr = avs_write && ack_r;
  assign rd = avs_read && !ack_r;
  // One wait cycle, answer on the second edge
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign avs_readdata = rdata_r;

  genvar gv;
  generate
    for (gv = 0; gv < xirq_pkg::NUM_VEC; gv++) begin : g_vec
      assign vec_event[gv] = slot_events(gv, src_event);
      always_comb begin
        route_nxt[gv] = route_r[gv];
        if (wr && avs_address == 6'(gv * 4)) begin
          // Flags only clear by software: writing one has no effect
          if (avs_byteenable[1])
            route_nxt[gv][15:8] = avs_writedata[15:8];
          if (avs_byteenable[0])
            route_nxt[gv][7:0] = route_r[gv][7:0] & avs_writedata[7:0];
        end
        // Set beats clear, regardless of enable
        route_nxt[gv][7:0] = route_nxt[gv][7:0] | vec_event[gv];
      end
      always_ff @(posedge core_clk) begin
        if (!reset_n)
          route_r[gv] <= xirq_pkg::ROUTE_RESET;
        else
          route_r[gv] <= route_nxt[gv];
      end
      assign shared_vector_req[gv] =
        |(route_r[gv][15:8] & route_r[gv][7:0]);
      assign evt_stat_nxt[gv] = vec_event[gv] != 8'h00 ? 1'b1 :
        ((rd && avs_address == xirq_pkg::EVT_STATUS_OFS) ? 1'b0 : evt_stat_r[gv]);
      vec_req_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        (route_r[gv][15:8] & route_r[gv][7:0]) != 8'h00 |-> shared_vector_req[gv])
        else $error("shared vector not raised");
      flag_set_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        vec_event[gv] != 8'h00 |=> (route_r[gv][7:0] & $past(vec_event[gv]))
          == $past(vec_event[gv]))
        else $error("event flag lost");
      flag_hold_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        !(wr && avs_address == 6'(gv * 4))
        |=> (route_r[gv][7:0] & $past(route_r[gv][7:0])) == $past(route_r[gv][7:0]))
        else $error("flag cleared without write");
      en_hold_a: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        !(wr && avs_address == 6'(gv * 4))
        |=> $stable(route_r[gv][15:8]))
        else $error("enables changed without write");
    end
  endgenerate

  always_comb begin
    trap_set = 16'h0000;
    trap_set[xirq_pkg::TF_NMI] = trap_event.nmi;
    trap_set[xirq_pkg::TF_STACK_OVERFLOW_FLAG] = trap_event.stack_over;
    trap_set[xirq_pkg::TF_STACK_UNDERFLOW_FLAG] = trap_event.stack_under;
    trap_set[xirq_pkg::TF_UNDEFINED_OPCODE_FLAG] = trap_event.undef_opcode;
    trap_set[xirq_pkg::TF_MAC] = trap_event.mac_trap;
    trap_set[xirq_pkg::TF_PROTECTED_INSTR_FAULT_FLAG] = trap_event.prot_fault;
    trap_set[xirq_pkg::TF_ILLEGAL_OPERAND_FLAG] = trap_event.ill_operand;
    trap_set[xirq_pkg::TF_ILLEGAL_FETCH_FLAG] = trap_event.ill_fetch;
    trap_set[xirq_pkg::TF_ILLEGAL_EXT_BUS_FLAG] = trap_event.ill_ext_bus;
  end

  // Priority: reset, then class A in fixed order, then class B
  always_comb begin
    pend = '0;
    pend.ilvl = xirq_pkg::ILVL_MAX;
    if (reset_pend_r) begin
      pend.valid = 1'b1;
      pend.prio = xirq_pkg::PRIO_RESET;
      pend.number = xirq_pkg::TRAPNO_RESET;
      pend.vector = xirq_pkg::VEC_RESET_LOC;
    end else if (tflag_r[xirq_pkg::TF_NMI]) begin
      pend.valid = 1'b1;
      pend.prio = xirq_pkg::PRIO_CLASS_A;
      pend.number = xirq_pkg::TRAPNO_NMI;
      pend.vector = xirq_pkg::VEC_NMI_LOC;
    end else if (tflag_r[xirq_pkg::TF_STACK_OVERFLOW_FLAG]) begin
      pend.valid = 1'b1;
      pend.prio = xirq_pkg::PRIO_CLASS_A;
      pend.number = xirq_pkg::TRAPNO_STACK_OVERFLOW_FLAG;
      pend.vector = xirq_pkg::VEC_STACK_OVERFLOW_FLAG_LOC;
    end else if (tflag_r[xirq_pkg::TF_STACK_UNDERFLOW_FLAG]) begin
      pend.valid = 1'b1;
      pend.prio = xirq_pkg::PRIO_CLASS_A;
      pend.number = xirq_pkg::TRAPNO_STACK_UNDERFLOW_FLAG;
      pend.vector = xirq_pkg::VEC_STACK_UNDERFLOW_FLAG_LOC;
    end else if (tflag_r[7:0] != 8'h00) begin
      pend.valid = 1'b1;
      pend.prio = xirq_pkg::PRIO_CLASS_B;
      pend.number = xirq_pkg::TRAPNO_CLASSB;
      pend.vector = xirq_pkg::VEC_CLASSB_LOC;
    end
    // While a trap runs, only class B entries are held back; reset and class A are still offered
    if (in_service_r && pend.prio == xirq_pkg::PRIO_CLASS_B && !reset_pend_r)
      pend.valid = 1'b0;
  end
  assign trap_out = pend;

  always_comb begin
    tflag_nxt = tflag_r;
    evt_mask_nxt = evt_mask_r;
    reset_pend_nxt = reset_pend_r | reset_event;
    in_service_nxt = in_service_r;
    ack_nxt = (avs_read || avs_write) && !ack_r;
    rdata_nxt = 32'h00000000;
    if (wr && avs_address == xirq_pkg::TRAP_FLAG_OFS)
      tflag_nxt = merge16(tflag_r, tflag_r & avs_writedata[15:0], avs_byteenable[1:0]);
    if (wr && avs_address == xirq_pkg::EVT_MASK_OFS && avs_byteenable[0])
      evt_mask_nxt = avs_writedata[3:0];
    tflag_nxt = tflag_nxt | trap_set;
    if (trap_ack && pend.valid) begin
      in_service_nxt = 1'b1;
      if (pend.prio == xirq_pkg::PRIO_RESET)
        reset_pend_nxt = reset_event;
    end else if (trap_done)
      in_service_nxt = 1'b0;
    if (rd) begin
      case (avs_address)
        xirq_pkg::ROUTE0_OFS: rdata_nxt[15:0] = route_r[0];
        xirq_pkg::ROUTE1_OFS: rdata_nxt[15:0] = route_r[1];
        xirq_pkg::ROUTE2_OFS: rdata_nxt[15:0] = route_r[2];
        xirq_pkg::ROUTE3_OFS: rdata_nxt[15:0] = route_r[3];
        xirq_pkg::TRAP_FLAG_OFS: rdata_nxt[15:0] = tflag_r;
        xirq_pkg::EVT_STATUS_OFS: rdata_nxt[3:0] = evt_stat_r;
        xirq_pkg::EVT_MASK_OFS: rdata_nxt[3:0] = evt_mask_r;
        xirq_pkg::TRAP_STATE_OFS: rdata_nxt[2:0] = {reset_pend_r, in_service_r, pend.valid};
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      tflag_r <= xirq_pkg::TRAP_FLAG_RESET;
      evt_stat_r <= 4'h0;
      evt_mask_r <= xirq_pkg::EVT_MASK_RESET;
      in_service_r <= 1'b0;
      reset_pend_r <= 1'b1;
      ack_r <= 1'b0;
      rdata_r <= 32'h00000000;
    end else begin
      tflag_r <= tflag_nxt;
      evt_stat_r <= evt_stat_nxt;
      evt_mask_r <= evt_mask_nxt;
      in_service_r <= in_service_nxt;
      reset_pend_r <= reset_pend_nxt;
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign std_irq_block = in_service_r;
  assign cpu_interrupt_level = xirq_pkg::ILVL_MAX;
  assign level_force = trap_ack && pend.valid;
  assign irq = |(evt_stat_r & evt_mask_r);

  // Trap entry selection
  reset_first_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    reset_pend_r
    |-> trap_out.valid && trap_out.vector == 16'h0000 && trap_out.number == 8'h00)
    else $error("reset not highest");

  reset_ack_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    trap_ack && reset_pend_r && !reset_event
    |=> !reset_pend_r)
    else $error("reset entry not retired");

  nmi_vec_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !reset_pend_r && tflag_r[15]
    |-> trap_out.vector == 16'h0008 && trap_out.number == 8'h02)
    else $error("nmi vector wrong");

  class_a_over_b_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !reset_pend_r && tflag_r[14] && !tflag_r[15] && tflag_r[7:0] != 8'h00
    |-> trap_out.prio == xirq_pkg::PRIO_CLASS_A && trap_out.vector == 16'h0010)
    else $error("class A not above B");

  stack_underflow_flag_vec_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !reset_pend_r && tflag_r[15:13] == 3'b001
    |-> trap_out.vector == 16'h0018 && trap_out.number == 8'h06)
    else $error("underflow vector wrong");

  class_b_vec_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    trap_out.prio == xirq_pkg::PRIO_CLASS_B
    |-> trap_out.vector == 16'h0028 && trap_out.number == 8'h0A)
    else $error("class B vector wrong");

  classb_block_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    in_service_r && !reset_pend_r && tflag_r[15:13] == 3'b000
    |-> !trap_out.valid)
    else $error("class B offered in service");

  trap_flag_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    trap_event.ill_ext_bus
    |=> tflag_r[0])
    else $error("trap flag not set");

  trap_set_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    trap_set != 16'h0000
    |=> (tflag_r & $past(trap_set)) == $past(trap_set))
    else $error("trap flag lost");

  tflag_hold_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !(wr && avs_address == xirq_pkg::TRAP_FLAG_OFS)
    |=> (tflag_r & $past(tflag_r)) == $past(tflag_r))
    else $error("trap flag dropped");

  ilvl_force_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    level_force
    |-> cpu_interrupt_level == 4'hF)
    else $error("level not forced");

  ilvl_entry_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    trap_out.valid
    |-> trap_out.ilvl == 4'hF)
    else $error("entry level wrong");

  service_block_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    trap_ack && trap_out.valid && !trap_done
    |=> std_irq_block [*2] or (std_irq_block ##1 trap_done))
    else $error("service not blocking");

  // Register bus
  wait_once_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest)
    else $error("more than one wait state");

  // Source routing
  slot_unused_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    1'b1
    |-> !route_r[3][7])
    else $error("unused vector 3 slot set");

  err_route_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    src_event[xirq_pkg::SRC_I2C_ERR]
    |=> route_r[3][2])
    else $error("error source not on vector 3");

  pll_route_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    src_event[xirq_pkg::SRC_PLL_OSC]
    |=> route_r[3][5])
    else $error("clock source not on vector 3");

  can_a_route_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    src_event[xirq_pkg::SRC_CAN_A]
    |=> route_r[0][0] && route_r[3][0])
    else $error("CAN A routing wrong");

  can_b_route_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    src_event[xirq_pkg::SRC_CAN_B]
    |=> route_r[1][0] && route_r[3][1])
    else $error("CAN B routing wrong");

  pwm_route_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    src_event[xirq_pkg::SRC_PWM]
    |=> route_r[2][0] && route_r[3][6])
    else $error("PWM routing wrong");

  txb_route_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    src_event[xirq_pkg::SRC_ASC_TXB]
    |=> route_r[0][7] && route_r[1][7] && route_r[2][7])
    else $error("buffer source routing wrong");
endmodule // xperiph_irq_mux
`default_nettype wire

// [tb/core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input wire logic core_clk, // CPU clock
  input wire logic reset_n, // Reset, low active
  input wire logic ack_en, // Core willing to take traps
  input wire xirq_pkg::trap_entry_t trap_out, // Offered trap
  output logic trap_ack, // Trap taken
  output logic trap_done // Service left
);
  // Service runs a fixed span so the bench can act while it is in progress
  logic busy_r;
  logic [3:0] cnt_r;
  always_ff @(posedge core_clk) begin
    trap_ack <= 1'b0;
    trap_done <= 1'b0;
    if (!reset_n) begin
      busy_r <= 1'b0;
      cnt_r <= 4'h0;
    end else if (busy_r) begin
      cnt_r <= cnt_r + 4'h1;
      if (cnt_r == 4'h6) begin
        trap_done <= 1'b1;
        busy_r <= 1'b0;
      end
    end else if (ack_en && trap_out.valid) begin
      trap_ack <= 1'b1;
      busy_r <= 1'b1;
      cnt_r <= 4'h0;
    end
  end
endmodule // core_model
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [13:0] src_event = 14'h0000;
  xirq_pkg::trap_req_t trap_event = '0;
  logic reset_event = 1'b0;
  logic ack_en = 1'b0;
  logic trap_ack, trap_done, level_force, std_irq_block, irq;
  logic [3:0] shared_vector_req, cpu_interrupt_level;
  xirq_pkg::trap_entry_t trap_out;
  int mismatches = 0;
  int n_compared = 0;
  localparam int T0[8] = '{0, 2, 3, 5, 6, 8, 9, 10};
  localparam int T3[8] = '{0, 1, 4, 7, 11, 12, 13, 0};
  localparam int TFP[9] = '{0, 1, 2, 3, 6, 7, 13, 14, 15};
  xperiph_irq_mux uut (.core_clk(core_clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'h3), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .src_event(src_event), .trap_event(trap_event), .reset_event(reset_event),
    .trap_ack(trap_ack), .trap_done(trap_done), .shared_vector_req(shared_vector_req),
    .trap_out(trap_out), .cpu_interrupt_level(cpu_interrupt_level), .level_force(level_force),
    .std_irq_block(std_irq_block), .irq(irq));
  core_model core (.core_clk(core_clk), .reset_n(reset_n), .ack_en(ack_en),
    .trap_out(trap_out), .trap_ack(trap_ack), .trap_done(trap_done));
  always #10 core_clk = ~core_clk;
  task automatic fail(input string m);
    mismatches++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_compared++;
    if (g !== e) fail(m);
  endtask
  task automatic chk_ent(input logic [25:0] e, input string m);
    chk({trap_out.prio, trap_out.number, trap_out.vector}, e, m);
  endtask
  task automatic bus(input logic wr, input logic [5:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {16'h0000, d};
    // Sampled at the rising edge, before that edge updates the slave
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata[15:0];
    if (avs_waitrequest !== 1'b0) begin
      fail("bus timeout");
      wrap_up;
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(negedge core_clk);
  endtask
  task automatic pulse_src(input logic [13:0] m);
    @(posedge core_clk);
    src_event <= m;
    @(posedge core_clk);
    src_event <= 14'h0000;
    @(negedge core_clk);
  endtask
  task automatic pulse_trap(input logic [8:0] t, input logic rst);
    @(posedge core_clk);
    trap_event <= xirq_pkg::trap_req_t'(t);
    reset_event <= rst;
    @(posedge core_clk);
    trap_event <= '0;
    reset_event <= 1'b0;
    @(negedge core_clk);
  endtask
  task automatic wait_blk(input logic lvl);
    int n;
    for (n = 0; n < 40 && std_irq_block !== lvl; n++) @(negedge core_clk);
    chk(std_irq_block, lvl, "service block level");
  endtask
  task automatic t_reset;
    logic [15:0] q;
    chk_ent({xirq_pkg::PRIO_RESET, xirq_pkg::TRAPNO_RESET, xirq_pkg::VEC_RESET_LOC}, "rst");
    for (int v = 0; v < 4; v++) begin
      bus(1'b0, 6'(v * 4), 16'h0000, q);
      chk(q, xirq_pkg::ROUTE_RESET, "route reset");
    end
    bus(1'b0, xirq_pkg::TRAP_STATE_OFS, 16'h0000, q);
    chk(q, 16'h0005, "trap state after reset");
    chk(trap_out.ilvl, xirq_pkg::ILVL_MAX, "entry level");
    @(posedge core_clk);
    ack_en <= 1'b1;
    wait_blk(1'b1);
    chk(cpu_interrupt_level, xirq_pkg::ILVL_MAX, "level");
    @(posedge core_clk);
    ack_en <= 1'b0;
    wait_blk(1'b0);
    chk(trap_out.valid, 1'b0, "reset still pending");
    bus(1'b0, xirq_pkg::TRAP_STATE_OFS, 16'h0000, q);
    chk(q, 16'h0000, "trap state idle");
  endtask
  task automatic t_route;
    logic [15:0] q;
    int s;
    for (int v = 0; v < 4; v++) begin
      for (int k = 0; k < (v == 3 ? 7 : 8); k++) begin
        s = v == 3 ? T3[k] : (k != 0 ? T0[k] : (v == 2 ? 13 : v));
        bus(1'b1, 6'(v * 4), 16'hFF00, q);
        pulse_src(14'h0001 << s);
        bus(1'b0, 6'(v * 4), 16'h0000, q);
        chk(q, 16'hFF00 | (16'h0001 << k), "slot flag");
        chk(shared_vector_req[v], 1'b1, "vector request");
      end
    end
    for (int v = 0; v < 3; v++) bus(1'b1, 6'(v * 4), 16'hFF00, q);
    pulse_src(14'h1890);
    for (int v = 0; v < 3; v++) begin
      bus(1'b0, 6'(v * 4), 16'h0000, q);
      chk(q, 16'hFF00, "error source leaked");
    end
    chk(shared_vector_req[2:0], 3'h0, "error request leaked");
  endtask
  task automatic t_mask;
    logic [15:0] q;
    bus(1'b1, xirq_pkg::ROUTE0_OFS, 16'h0000, q);
    pulse_src(14'h0004);
    bus(1'b0, xirq_pkg::ROUTE0_OFS, 16'h0000, q);
    chk(q, 16'h0002, "masked flag");
    chk(shared_vector_req[0], 1'b0, "masked request");
    bus(1'b1, xirq_pkg::ROUTE0_OFS, 16'h02FF, q);
    bus(1'b0, xirq_pkg::ROUTE0_OFS, 16'h0000, q);
    chk(q, 16'h0202, "flag kept on one");
    chk(shared_vector_req[0], 1'b1, "enabled request");
    bus(1'b1, xirq_pkg::ROUTE0_OFS, 16'h02FD, q);
    bus(1'b0, xirq_pkg::ROUTE0_OFS, 16'h0000, q);
    chk(q, 16'h0200, "flag clear");
    chk(shared_vector_req[0], 1'b0, "request after clear");
  endtask
  task automatic t_irq;
    logic [15:0] q;
    bus(1'b0, xirq_pkg::EVT_MASK_OFS, 16'h0000, q);
    chk(q, 16'(xirq_pkg::EVT_MASK_RESET), "mask reset");
    bus(1'b0, xirq_pkg::EVT_STATUS_OFS, 16'h0000, q);
    pulse_src(14'h1000);
    chk(irq, 1'b0, "masked irq");
    bus(1'b1, xirq_pkg::EVT_MASK_OFS, 16'h0008, q);
    chk(irq, 1'b1, "irq raised");
    bus(0, xirq_pkg::EVT_STATUS_OFS, 16'h0000, q);
    chk(q, 16'h0008, "status");
    chk(irq, 1'b0, "irq after read clear");
    bus(1'b1, 6'h20, 16'hFFFF, q);
    bus(1'b0, 6'h20, 16'h0000, q);
    chk(q, 16'h0000, "unmapped read");
  endtask
  task automatic t_traps;
    logic [15:0] q;
    logic [15:0] msk;
    logic [25:0] ents[4] = '{
      {xirq_pkg::PRIO_CLASS_A, xirq_pkg::TRAPNO_NMI, xirq_pkg::VEC_NMI_LOC},
      {xirq_pkg::PRIO_CLASS_A, xirq_pkg::TRAPNO_STACK_OVERFLOW_FLAG, xirq_pkg::VEC_STACK_OVERFLOW_FLAG_LOC},
      {xirq_pkg::PRIO_CLASS_A, xirq_pkg::TRAPNO_STACK_UNDERFLOW_FLAG, xirq_pkg::VEC_STACK_UNDERFLOW_FLAG_LOC},
      {xirq_pkg::PRIO_CLASS_B, xirq_pkg::TRAPNO_CLASSB, xirq_pkg::VEC_CLASSB_LOC}};
    for (int k = 0; k < 9; k++) begin
      pulse_trap(9'h001 << k, 1'b0);
      bus(1'b0, xirq_pkg::TRAP_FLAG_OFS, 16'h0000, q);
      chk(q, 16'h0001 << TFP[k], "trap flag bit");
      chk_ent(ents[k < 6 ? 3 : 8 - k], "single trap entry");
      bus(1'b1, xirq_pkg::TRAP_FLAG_OFS, 16'h0000, q);
    end
    pulse_trap(9'h1FF, 1'b0);
    msk = 16'hE0CF;
    for (int i = 0; i < 3; i++) begin
      chk_ent(ents[i], "class A order");
      msk[15 - i] = 1'b0;
      bus(1'b1, xirq_pkg::TRAP_FLAG_OFS, msk, q);
    end
    chk_ent(ents[3], "class B last");
    pulse_trap(9'h100, 1'b1);
    chk_ent({xirq_pkg::PRIO_RESET, xirq_pkg::TRAPNO_RESET, xirq_pkg::VEC_RESET_LOC}, "r");
    @(posedge core_clk);
    ack_en <= 1'b1;
    wait_blk(1'b1);
    @(posedge core_clk);
    ack_en <= 1'b0;
    @(negedge core_clk);
    chk_ent(ents[0], "nmi after reset");
    bus(1'b1, xirq_pkg::TRAP_FLAG_OFS, 16'h0000, q);
    wait_blk(1'b0);
    chk(trap_out.valid, 1'b0, "trap left pending");
  endtask
  always @(negedge core_clk) if (trap_ack) chk(level_force, 1'b1, "level not forced");
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #1000000;
    fail("watchdog");
    wrap_up;
  end
  initial begin
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    t_reset;
    t_route;
    t_mask;
    t_irq;
    t_traps;
    wrap_up;
  end
endmodule // testbench
`default_nettype wire
